// *** rtl/timer_ch_consts.vh ***
/*
  constants for one 16-bit timer channel with prescaler, capture and
  pulse generation. assumes an apb slave with 32-bit data.
*/
`ifndef TIMER_CH_CONSTS_VH
`define TIMER_CH_CONSTS_VH

// register byte offsets
`define OFS_CONTROL     5'h00
`define OFS_A_COMPARE   5'h04
`define OFS_B_COMPARE   5'h08
`define OFS_CAPTURE     5'h0C
`define OFS_PRESCALE    5'h10
`define OFS_COUNT       5'h14

// control field positions
`define BIT_RUN         15
`define BIT_CLK_SEL     14
`define BIT_MODE_HI     13
`define BIT_MODE_LO     12
`define BIT_EXT_EDGE    11
`define BIT_OUT_LEVEL   8
`define BIT_CAP_HI      7
`define BIT_CAP_LO      6
`define BIT_MATCH_IEN   5
`define BIT_CAP_IEN     4
`define BIT_MATCH_FLAG  3
`define BIT_CAP_FLAG    2
`define BIT_HOLD        1
`define BIT_WIPE        0

// modes and capture edges
`define MODE_COUNTER    2'h0
`define MODE_CAPTURE    2'h1
`define MODE_PULSE_ONE  2'h2
`define MODE_PULSE_REP  2'h3
`define CAP_FALL        2'h0
`define CAP_RISE        2'h1
`define CAP_BOTH        2'h2

// reset values
`define RST_A_COMPARE   16'hFFFF
`define RST_B_COMPARE   16'hFFFF
`define RST_PRESCALE    12'hFFF
`define ZERO16          16'h0000
`define ZERO12          12'h000
`define ONE16           16'h0001
`define ONE12           12'h001
`define ZERO32          32'h0000_0000

`endif

// *** rtl/timer_channel.v ***
/*
  one 16-bit timer channel: apb register slave, 12-bit prescaler,
  external clock and capture inputs synchronised to i_clk, counter,
  a/b compare, waveform output and gated interrupt requests.
  the channel is used once per timer; each copy is independent.
  assumes external pins are asynchronous and slow against i_clk:
  each high and low phase of a pin must last over one clock,
  or the edge detector can miss it.
  assumes software keeps the a value in range and changes clock
  source and mode only while the channel is stopped.
*/
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "timer_ch_consts.vh"

module timer_channel (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [31:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // pins
  input  wire        i_ext_count_clock_in,
  input  wire        i_capture_in,
  output reg         o_waveform_out,
  // interrupt requests
  output reg         o_match_irq,
  output reg         o_capture_irq
);

  // control fields
  reg        channel_run_q;
  reg        clock_source_select_q;
  reg [1:0]  operating_mode_field_q;
  reg        ext_clock_edge_select_q;
  reg        output_start_level_q;
  reg [1:0]  capture_edge_select_q;
  reg        match_irq_enable_q;
  reg        capture_irq_enable_q;
  reg        match_irq_flag_q;
  reg        capture_irq_flag_q;
  reg        count_hold_q;
  reg [15:0] a_compare_value_q;
  reg [15:0] b_compare_value_q;
  reg [15:0] captured_value_q;
  reg [11:0] prescale_divisor_q;
  reg [15:0] count_value_q;
  reg [11:0] presc_q;
  reg        done_q;
  reg        out_q;

  // next values of the counting path
  reg [11:0] presc_d;
  reg [15:0] count_value_d;
  reg        done_d;
  reg        out_d;

  // synchronised pin edges
  wire       ec_rise;
  wire       ec_fall;
  wire       cap_rise;
  wire       cap_fall;

  // apb decode; slave answers in the access cycle, zero wait
  wire       access   = i_psel & i_penable;
  wire       wr       = access & i_pwrite;
  wire [4:0] ofs      = i_paddr[4:0];
  wire       mapped   = (i_paddr[31:5] == 27'h0000000) &&
                        (ofs == `OFS_CONTROL || ofs == `OFS_A_COMPARE ||
                         ofs == `OFS_B_COMPARE || ofs == `OFS_CAPTURE ||
                         ofs == `OFS_PRESCALE || ofs == `OFS_COUNT);
  wire       wr_ctrl  = wr && mapped && ofs == `OFS_CONTROL;
  wire       start    = wr_ctrl && i_pwdata[`BIT_RUN] && !channel_run_q;
  wire       wipe     = wr_ctrl && i_pwdata[`BIT_WIPE];
  // flag clear strobes; a one clears, a zero leaves the flag alone
  wire       clr_match = wr_ctrl & i_pwdata[`BIT_MATCH_FLAG];
  wire       clr_capt  = wr_ctrl & i_pwdata[`BIT_CAP_FLAG];
  // answer terms, registered so the bus sees clean flops
  wire       setup_ph  = i_psel & ~i_penable;
  wire       rd_setup  = setup_ph & ~i_pwrite & mapped;

  // tick sources
  wire       presc_end = (presc_q == prescale_divisor_q);
  wire       ext_tick  = ext_clock_edge_select_q ? ec_rise : ec_fall;
  wire       tick      = clock_source_select_q ? ext_tick : presc_end;
  wire       counting  = channel_run_q & ~count_hold_q & ~done_q;
  wire       advance   = counting & tick;
  wire       a_match   = advance && (count_value_q == a_compare_value_q);
  wire       b_match   = advance && (count_value_q == b_compare_value_q);

  // mode decode
  wire       is_counter = (operating_mode_field_q == `MODE_COUNTER);
  wire       is_capture = (operating_mode_field_q == `MODE_CAPTURE);
  wire       is_one     = (operating_mode_field_q == `MODE_PULSE_ONE);
  wire       is_repeat  = (operating_mode_field_q == `MODE_PULSE_REP);
  wire       is_pulse   = is_one | is_repeat;

  // capture edge select
  reg        cap_edge;
  always @* begin
    case (capture_edge_select_q)
      `CAP_FALL: cap_edge = cap_fall;
      `CAP_RISE: cap_edge = cap_rise;
      `CAP_BOTH: cap_edge = cap_rise | cap_fall;
      default:   cap_edge = 1'b0; // reserved code captures nothing
    endcase
  end
  wire cap_event = channel_run_q & is_capture & cap_edge;

  // read mux
  reg [31:0] rdata;
  always @* begin
    rdata = `ZERO32;
    case (ofs)
      `OFS_CONTROL: begin
        rdata[`BIT_RUN]        = channel_run_q;
        rdata[`BIT_CLK_SEL]    = clock_source_select_q;
        rdata[`BIT_MODE_HI:`BIT_MODE_LO] = operating_mode_field_q;
        rdata[`BIT_EXT_EDGE]   = ext_clock_edge_select_q;
        rdata[`BIT_OUT_LEVEL]  = output_start_level_q;
        rdata[`BIT_CAP_HI:`BIT_CAP_LO] = capture_edge_select_q;
        rdata[`BIT_MATCH_IEN]  = match_irq_enable_q;
        rdata[`BIT_CAP_IEN]    = capture_irq_enable_q;
        rdata[`BIT_MATCH_FLAG] = match_irq_flag_q;
        rdata[`BIT_CAP_FLAG]   = capture_irq_flag_q;
        rdata[`BIT_HOLD]       = count_hold_q; // wipe reads 0
      end
      `OFS_A_COMPARE: rdata[15:0] = a_compare_value_q;
      `OFS_B_COMPARE: rdata[15:0] = b_compare_value_q;
      `OFS_CAPTURE:   rdata[15:0] = captured_value_q;
      `OFS_PRESCALE:  rdata[11:0] = prescale_divisor_q;
      `OFS_COUNT:     rdata[15:0] = count_value_q;
      default:        rdata = `ZERO32;
    endcase
  end

  // bus answer registers; pready high one cycle after setup
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= `ZERO32;
    end else begin
      o_pready  <= setup_ph;
      o_pslverr <= setup_ph & ~mapped;
      o_prdata  <= rd_setup ? rdata : `ZERO32;
    end
  end

  // control and data registers
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      channel_run_q           <= 1'b0;
      clock_source_select_q   <= 1'b0;
      operating_mode_field_q  <= `MODE_COUNTER;
      ext_clock_edge_select_q <= 1'b0;
      output_start_level_q    <= 1'b0;
      capture_edge_select_q   <= `CAP_FALL;
      match_irq_enable_q      <= 1'b0;
      capture_irq_enable_q    <= 1'b0;
      count_hold_q            <= 1'b0;
      a_compare_value_q       <= `RST_A_COMPARE;
      b_compare_value_q       <= `RST_B_COMPARE;
      prescale_divisor_q      <= `RST_PRESCALE;
    end else if (wr && mapped) begin
      case (ofs)
        `OFS_CONTROL: begin
          channel_run_q           <= i_pwdata[`BIT_RUN];
          clock_source_select_q   <= i_pwdata[`BIT_CLK_SEL];
          operating_mode_field_q  <=
            i_pwdata[`BIT_MODE_HI:`BIT_MODE_LO];
          ext_clock_edge_select_q <= i_pwdata[`BIT_EXT_EDGE];
          output_start_level_q    <= i_pwdata[`BIT_OUT_LEVEL];
          capture_edge_select_q   <= i_pwdata[`BIT_CAP_HI:`BIT_CAP_LO];
          match_irq_enable_q      <= i_pwdata[`BIT_MATCH_IEN];
          capture_irq_enable_q    <= i_pwdata[`BIT_CAP_IEN];
          count_hold_q            <= i_pwdata[`BIT_HOLD];
        end
        `OFS_A_COMPARE: a_compare_value_q  <= i_pwdata[15:0];
        `OFS_B_COMPARE: b_compare_value_q  <= i_pwdata[15:0];
        `OFS_PRESCALE:  prescale_divisor_q <= i_pwdata[11:0];
        default: ;
      endcase
    end
  end

  // sticky flags; an event in the clearing cycle wins
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      match_irq_flag_q   <= 1'b0;
      capture_irq_flag_q <= 1'b0;
    end else begin
      if (a_match)
        match_irq_flag_q <= 1'b1;
      else if (clr_match)
        match_irq_flag_q <= 1'b0;
      if (cap_event)
        capture_irq_flag_q <= 1'b1;
      else if (clr_capt)
        capture_irq_flag_q <= 1'b0;
    end
  end

  // two-stage synchronisers per pin; edges come off the second stage
  pin_sync_edge ec_sync (
    .i_clk  (i_clk),
    .i_rst  (i_sys_rst),
    .i_pin  (i_ext_count_clock_in),
    .o_rise (ec_rise),
    .o_fall (ec_fall)
  );
  pin_sync_edge cap_sync (
    .i_clk  (i_clk),
    .i_rst  (i_sys_rst),
    .i_pin  (i_capture_in),
    .o_rise (cap_rise),
    .o_fall (cap_fall)
  );

  // prescaler next value: free while running and not held, restarts on start or wipe
  always @* begin
    presc_d = presc_q;
    if (start || wipe || !channel_run_q)
      presc_d = `ZERO12;
    else if (presc_end)
      presc_d = `ZERO12;
    else if (!count_hold_q)
      presc_d = presc_q + `ONE12;
  end

  // hold also freezes the prescaler, except that at its end value it still wraps to zero
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      presc_q <= `ZERO12;
    else
      presc_q <= presc_d;
  end

  // counter and one-shot stop, next values
  always @* begin
    count_value_d = count_value_q;
    done_d        = done_q;
    if (start || wipe) begin
      count_value_d = `ZERO16;
      done_d        = 1'b0;
    end else if (a_match) begin
      count_value_d = `ZERO16;
      if (is_one)
        done_d = 1'b1;
    end else if (advance)
      count_value_d = count_value_q + `ONE16;
  end

  // counter, capture register and one-shot stop
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_value_q    <= `ZERO16;
      captured_value_q <= `ZERO16;
      done_q           <= 1'b0;
    end else begin
      count_value_q <= count_value_d;
      done_q        <= done_d;
      if (cap_event)
        captured_value_q <= count_value_q;
    end
  end

  // waveform phase next value; start phase on start or wipe
  always @* begin
    out_d = out_q;
    if (start || wipe)
      out_d = 1'b1; // start phase
    else if (is_counter && a_match)
      out_d = ~out_q;
    else if (is_pulse && a_match)
      out_d = is_repeat;
    else if (is_pulse && b_match)
      out_d = 1'b0;
  end

  // phase register; reset puts it in the start phase
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      out_q <= 1'b1;
    else
      out_q <= out_d;
  end

  // pin drive: polarity applies; idle and capture hold the idle level
  wire idle_lvl  = output_start_level_q;
  wire match_req = match_irq_flag_q & match_irq_enable_q;
  wire capt_req  = capture_irq_flag_q & capture_irq_enable_q;
  reg  pin_d;
  always @* begin
    if (!channel_run_q || is_capture)
      pin_d = idle_lvl;
    else
      pin_d = out_q ^ output_start_level_q;
  end
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_waveform_out <= 1'b0;
      o_match_irq    <= 1'b0;
      o_capture_irq  <= 1'b0;
    end else begin
      o_waveform_out <= pin_d;
      o_match_irq    <= match_req;
      o_capture_irq  <= capt_req;
    end
  end

endmodule // timer_channel

// two flip-flop synchroniser with edge detection off the second stage;
// history resets to the idle low level so no false edge follows reset
module pin_sync_edge (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst,
  // pin and its edges
  input  wire i_pin,
  output wire o_rise,
  output wire o_fall
);

  reg s1_q;
  reg s2_q;
  reg prev_q;

  // only the second stage feeds logic; the first may go metastable
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= i_pin;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  // one-cycle edge pulses
  assign o_rise = s2_q & ~prev_q;
  assign o_fall = ~s2_q & prev_q;

endmodule // pin_sync_edge

// *** dv/timer_channel_props.sv ***
/* checker for one timer channel, seen from its ports only.
   assumes a single clock and a zero-wait apb slave. */
`timescale 1ns/1ps
module timer_channel_chk (
  // clock and reset
  input wire        i_clk,
  input wire        i_sys_rst,
  // apb
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  // pins and requests
  input wire        i_ext_count_clock_in,
  input wire        i_capture_in,
  input wire        o_waveform_out,
  input wire        o_match_irq,
  input wire        o_capture_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // decoded request phases
  wire setup  = i_psel & ~i_penable;
  wire wr_ctl = i_psel & i_penable & i_pwrite & (i_paddr == 32'h0);
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_answer; setup |=> o_pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_err; setup && i_paddr > 32'h14 |=> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_no_err;
    setup && i_paddr <= 32'h14 && i_paddr[1:0] == 2'h0 |=> !o_pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("mapped refused");
  property p_rd_idle; !o_pready |-> o_prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
  property p_mirq; wr_ctl && !i_pwdata[5] |-> ##2 !o_match_irq; endproperty
  a_mirq: assert property (p_mirq) else $error("match req ungated");
  property p_cirq; wr_ctl && !i_pwdata[4] |-> ##2 !o_capture_irq; endproperty
  a_cirq: assert property (p_cirq) else $error("capt req ungated");
  property p_idle;
    wr_ctl && !i_pwdata[15] |-> ##2 o_waveform_out == $past(i_pwdata[8], 2);
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  // main scenarios reached
  c_match: cover property ($rose(o_match_irq));
  c_capt: cover property ($rose(o_capture_irq));
  c_err: cover property (o_pslverr);
endmodule // timer_channel_chk

bind timer_channel timer_channel_chk chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_ext_count_clock_in(i_ext_count_clock_in),
  .i_capture_in(i_capture_in), .o_waveform_out(o_waveform_out),
  .o_match_irq(o_match_irq), .o_capture_irq(o_capture_irq));

// *** dv/pin_model.sv ***
/* pin model: external count clock and capture pin.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
module pin_model (
  // clock
  input  wire  i_clk,
  // pins
  output logic o_ext_clk,
  output logic o_cap
);
  // count clock stands still low outside a burst
  initial begin
    o_ext_clk = 1'b0;
    o_cap = 1'b0;
  end
  // phases of four clocks, slow enough for the synchroniser
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ext_clk <= 1'b0;
    end
  endtask
  // capture level moves just after an edge
  task automatic cap_set(input logic v);
    @(posedge i_clk);
    o_cap <= v;
  endtask
endmodule // pin_model

// *** dv/timer_channel_bench.sv ***
/* bench for one timer channel: apb tasks and mode scenarios.
   assumes timer_channel, pin_model and timer_ch_consts.vh. */
`timescale 1ns/1ps
`include "timer_ch_consts.vh"
module timer_channel_bench;
  logic        i_clk, i_sys_rst, psel, pen, pwr, pready, er, perr;
  logic [31:0] paddr, pwdata, prdata, r, c;
  logic        ext_clk, cap, wave, mirq, cirq;
  int          n_fail, checked, k, k2;
  logic [31:0] ofs[6] = '{`OFS_CONTROL, `OFS_A_COMPARE, `OFS_B_COMPARE,
                          `OFS_CAPTURE, `OFS_PRESCALE, `OFS_COUNT};
  logic [31:0] rv[6] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'hFFF, 32'h0};
  timer_channel dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .i_ext_count_clock_in(ext_clk), .i_capture_in(cap),
    .o_waveform_out(wave), .o_match_irq(mirq), .o_capture_irq(cirq));
  pin_model pins (.i_clk(i_clk), .o_ext_clk(ext_clk), .o_cap(cap));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d);
    int t;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
      n_fail++;
    r = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [31:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic tick(input int n); repeat (n) @(posedge i_clk); endtask
  // cycles until the output pin changes
  task automatic gap(output int n);
    logic v;
    v = wave;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wave === v && n < 300);
  endtask
  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, well beyond the few hundred cycles needed
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    {i_sys_rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 67'h0};
    tick(8);
    i_sys_rst <= 1'b0;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reset value", rv[i], r);
    end
    rd(32'h18);
    chk("slverr", 1, er);
    wr(`OFS_B_COMPARE, 32'h0);
    wr(`OFS_COUNT, 32'h1234);
    rd(`OFS_B_COMPARE);
    chk("b zero", 0, r);
    rd(`OFS_COUNT);
    chk("count ro", 0, r);
    // counter mode: divisor 1, a value 5
    wr(`OFS_PRESCALE, 1);
    wr(`OFS_A_COMPARE, 5);
    wr(`OFS_CONTROL, 32'h8020);
    k = 0;
    while (mirq !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk("match req", 1, mirq);
    gap(k);
    gap(k);
    chk("toggle gap", 12, k);
    wr(`OFS_CONTROL, 32'h8022);
    wr(`OFS_CONTROL, 32'h800A);
    rd(`OFS_CONTROL);
    chk("flag clear", 32'h8002, r);
    rd(`OFS_COUNT);
    c = r;
    tick(20);
    rd(`OFS_COUNT);
    chk("held", c, r);
    wr(`OFS_CONTROL, 32'h8003);
    rd(`OFS_COUNT);
    chk("wiped", 0, r);
    // capture on each edge choice
    wr(`OFS_CONTROL, 32'h0);
    for (int e = 0; e < 3; e++) begin
      wr(`OFS_CONTROL, 32'h9014 | e << 6);
      tick(9);
      wr(`OFS_CONTROL, 32'h9016 | e << 6);
      rd(`OFS_COUNT);
      c = r;
      pins.cap_set(1'b1);
      tick(8);
      rd(`OFS_CONTROL);
      chk("rise flag", e != 0, r[2]);
      chk("capt req", e != 0, cirq);
      pins.cap_set(1'b0);
      tick(8);
      rd(`OFS_CAPTURE);
      chk("capt data", c, r);
      chk("capt pin", 0, wave);
    end
    // external clock, both edges
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_A_COMPARE, 32'hFFFF);
    for (int e = 0; e < 2; e++) begin
      wr(`OFS_CONTROL, 32'h4000 | e << 11);
      wr(`OFS_CONTROL, 32'hC000 | e << 11);
      pins.ext_pulses(5);
      tick(8);
      rd(`OFS_COUNT);
      chk("ext count", 5, r);
    end
    // pulse repeat: period of a+1 ticks
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_PRESCALE, 0);
    wr(`OFS_A_COMPARE, 5);
    wr(`OFS_B_COMPARE, 2);
    wr(`OFS_CONTROL, 32'h3000);
    wr(`OFS_CONTROL, 32'hB000);
    gap(k);
    gap(k);
    gap(k2);
    chk("period", 6, k + k2);
    wr(`OFS_CONTROL, 32'h0100);
    rd(`OFS_CONTROL);
    chk("idle high", 1, wave);
    wr(`OFS_CONTROL, 32'h2000);
    wr(`OFS_CONTROL, 32'hA000);
    gap(k);
    chk("one shot pulse", 1, wave);
    tick(40);
    chk("one shot", 0, wave);
    results();
  end
endmodule // timer_channel_bench
